/* File: src/atd_pkg.sv */
// package for the trim and dither register bank
// assumes a plain address/strobe register port, 12-bit addresses
package atd_pkg;
    // ==================================================
    // bus geometry
    localparam int ADDR_W = 12; // byte address width
    localparam int DATA_W = 8;  // register width
    // ==================================================
    // register offsets
    localparam logic [11:0] OFS_GAIN_TRIM_B = 12'h07B;
    localparam logic [11:0] OFS_BANDGAP_TRIM = 12'h07C;
    localparam logic [11:0] OFS_TERM_TRIM_A = 12'h07E;
    localparam logic [11:0] OFS_TERM_TRIM_B = 12'h07F;
    localparam logic [11:0] OFS_DITHER_CTRL = 12'h09D;
    localparam logic [11:0] OFS_B0_TIME_ZERO = 12'h102;
    localparam logic [11:0] OFS_B0_TIME_QUAD = 12'h103;
    // ==================================================
    // field positions and masks
    localparam int DITH_EN_BIT = 0;   // dither enable
    localparam int DITH_AMP_BIT = 1;  // amplitude select
    localparam int DITH_ERR_BIT = 2;  // rounding error select
    localparam logic [7:0] BANDGAP_TRIM_MASK = 8'h0F;  // low nibble only
    localparam logic [7:0] DITH_MASK = 8'h07;     // bits 2:0 only
    // ==================================================
    // reset values and unmapped read answer
    localparam logic [7:0] DITH_RESET = 8'h01;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    // ==================================================
    // clocking mode of converter a
    typedef enum logic [0:0] {
        ATD_CLK_DUAL = 1'b0,   // zero-degree phase
        ATD_CLK_SINGLE = 1'b1  // minus-ninety phase
    } atd_clkmode_type;
endpackage

/* File: src/atd_trim_reg.sv */
// one trim register: loads fuse default after reset, then software owned
// assumes fuse_val is stable while fuse_load is high
`timescale 1ns/10ps
module atd_trim_reg
    import atd_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hFF  // implemented bits
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fuse_load,
    input wire logic [7:0] fuse_val,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    // ==================================================
    // storage
    logic [7:0] value_r; // held trim

    // reset gives a constant; the fuse copy lands on the load cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_r <= TRIM_RESET;
        end else if (fuse_load) begin
            value_r <= fuse_val & MASK;
        end else if (wr_en) begin
            value_r <= wr_data & MASK;
        end
    end

    assign value = value_r;
endmodule

/* File: src/atd_regs.sv */
// trim and dither register bank of a dual-input sampling converter
// assumes a synchronous register port and a fuse array whose contents
// are valid whenever fuse_ready is high
// Notes on behaviour
// - eight-bit read-write gain trim, input b
// - four-bit bandgap trim, upper nibble reserved zero
// - eight-bit read-write termination trim, input a
// - eight-bit read-write termination trim, input b
// - dither bit zero enables, resets to one
// - dither bit one picks amplitude, resets zero
// - dither bit two places rounding error
// - zero-phase bank0 trim applied in dual mode
// - quadrature bank0 trim applied in single mode
// - reset loads constant defaults; fuse values are copied once fuse_ready is seen
`timescale 1ns/10ps
module atd_regs
    import atd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // fuse storage
    input wire logic fuse_ready,
    input wire logic [7:0] fuse_gain_trim_b,
    input wire logic [7:0] fuse_bandgap_trim,
    input wire logic [7:0] fuse_term_trim_a,
    input wire logic [7:0] fuse_term_trim_b,
    input wire logic [7:0] fuse_dither_control,
    input wire logic [7:0] fuse_b0_time_zero,
    input wire logic [7:0] fuse_b0_time_quad,
    // clocking configuration, high for single-channel
    input wire logic single_channel,
    // analog-facing outputs
    output logic [7:0] gain_trim_b_out,
    output logic [3:0] bandgap_trim_out,
    output logic [7:0] term_trim_a_out,
    output logic [7:0] term_trim_b_out,
    output logic dither_enable,
    output logic dither_amplitude_select,
    output logic rounding_error_select,
    output logic [7:0] bank0_timing_out,
    output logic fuse_loaded
);
    // ==================================================
    // fuse load sequencing
    logic fuse_rdy_s1_r;   // first sync stage, read only by stage two
    logic fuse_rdy_s2_r;   // synchronised ready
    logic fuse_done_r;     // fuse copy finished
    logic fuse_load;       // one-cycle load pulse

    // fuse_ready is an async pin; two stages before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fuse_rdy_s1_r <= 1'b0;
            fuse_rdy_s2_r <= 1'b0;
        end else begin
            fuse_rdy_s1_r <= fuse_ready;
            fuse_rdy_s2_r <= fuse_rdy_s1_r;
        end
    end

    // load once per reset; writes before it are overwritten by fuses
    assign fuse_load = fuse_rdy_s2_r & ~fuse_done_r;

    // done flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fuse_done_r <= 1'b0;
        end else if (fuse_load) begin
            fuse_done_r <= 1'b1;
        end
    end

    assign fuse_loaded = fuse_done_r;

    // ==================================================
    // address decode
    logic [6:0] hit;        // one-hot select per register
    logic [7:0] val [7];    // register contents by index
    logic [7:0] fuse [7];   // fuse defaults by index
    logic [7:0] dith_raw;   // dither register copy, already masked

    // decode the seven offsets
    always_comb begin
        hit = 7'h00;
        case (reg_addr)
            OFS_GAIN_TRIM_B: hit[0] = 1'b1;
            OFS_BANDGAP_TRIM: hit[1] = 1'b1;
            OFS_TERM_TRIM_A: hit[2] = 1'b1;
            OFS_TERM_TRIM_B: hit[3] = 1'b1;
            OFS_DITHER_CTRL: hit[4] = 1'b1;
            OFS_B0_TIME_ZERO: hit[5] = 1'b1;
            OFS_B0_TIME_QUAD: hit[6] = 1'b1;
            default: hit = 7'h00; // unmapped
        endcase
    end

    // fuse sources in index order
    assign fuse[0] = fuse_gain_trim_b;
    assign fuse[1] = fuse_bandgap_trim;
    assign fuse[2] = fuse_term_trim_a;
    assign fuse[3] = fuse_term_trim_b;
    assign fuse[4] = fuse_dither_control;
    assign fuse[5] = fuse_b0_time_zero;
    assign fuse[6] = fuse_b0_time_quad;

    // ==================================================
    // plain eight-bit trims: gain b, term a, term b, both timings
    localparam int FULL_IDX [5] = '{0, 2, 3, 5, 6};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_full
            // full-width read-write trim
            atd_trim_reg #(
                .MASK(8'hFF)
            ) u_reg (
                .sys_clk(sys_clk),
                .rst(rst),
                .fuse_load(fuse_load),
                .fuse_val(fuse[FULL_IDX[gi]]),
                .wr_en(reg_wr & hit[FULL_IDX[gi]]),
                .wr_data(reg_wdata),
                .value(val[FULL_IDX[gi]])
            );
        end
    endgenerate

    // bandgap: reserved upper nibble forced to zero by the mask
    atd_trim_reg #(
        .MASK(BANDGAP_TRIM_MASK)
    ) u_bandgap (
        .sys_clk(sys_clk),
        .rst(rst),
        .fuse_load(fuse_load),
        .fuse_val(fuse[1]),
        .wr_en(reg_wr & hit[1]),
        .wr_data(reg_wdata),
        .value(val[1])
    );

    // ==================================================
    // dither control, own register so its reset value is one
    logic [7:0] dith_r; // dither control bits

    // reset enables dither; fuse copy and writes follow
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dith_r <= DITH_RESET;
        end else if (fuse_load) begin
            dith_r <= fuse[4] & DITH_MASK;
        end else if (reg_wr && hit[4]) begin
            dith_r <= reg_wdata & DITH_MASK;
        end
    end

    assign dith_raw = dith_r;
    assign val[4] = dith_raw;

    // ==================================================
    // read port: data stands in the cycle after the strobe only
    logic [7:0] rdata_r;   // read data register
    logic [7:0] rd_mux;    // selected value

    // select by one-hot hit; unmapped reads give zero
    always_comb begin
        rd_mux = UNMAPPED_RD;
        for (int i = 0; i < 7; i++) begin
            if (hit[i]) begin
                rd_mux = val[i];
            end
        end
    end

    // read data only valid one cycle, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    // ==================================================
    // analog-facing outputs, straight from the registers
    atd_clkmode_type clk_mode; // clocking of converter a
    assign clk_mode = single_channel ? ATD_CLK_SINGLE : ATD_CLK_DUAL;

    assign gain_trim_b_out = val[0];
    assign bandgap_trim_out = val[1][3:0];
    assign term_trim_a_out = val[2];
    assign term_trim_b_out = val[3];
    assign dither_enable = dith_r[DITH_EN_BIT];
    assign dither_amplitude_select = dith_r[DITH_AMP_BIT];
    assign rounding_error_select = dith_r[DITH_ERR_BIT];

    // mode picks which timing trim reaches bank 0
    always_comb begin
        case (clk_mode)
            ATD_CLK_DUAL: bank0_timing_out = val[5];
            ATD_CLK_SINGLE: bank0_timing_out = val[6];
            default: bank0_timing_out = val[5];
        endcase
    end

    // ==================================================
    // checks
    property p_dith_reset;
        @(posedge sys_clk) $fell(rst) |-> dither_enable
            && !dither_amplitude_select && !rounding_error_select;
    endproperty
    a_dith_reset: assert property (p_dith_reset)
        else $error("dither reset value wrong");

    property p_gain_wr;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_GAIN_TRIM_B && !fuse_load
            |=> gain_trim_b_out == $past(reg_wdata);
    endproperty
    a_gain_wr: assert property (p_gain_wr)
        else $error("gain trim b write not taken");

    property p_bg_rsvd;
        @(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_BANDGAP_TRIM |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_bg_rsvd: assert property (p_bg_rsvd)
        else $error("bandgap reserved bits nonzero");

    property p_terma_rd;
        @(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_TERM_TRIM_A
            |=> reg_rdata == $past(term_trim_a_out);
    endproperty
    a_terma_rd: assert property (p_terma_rd)
        else $error("term trim a readback mismatch");

    // a write reaches the analog side with no further trigger
    property p_terma_wr;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_TERM_TRIM_A && !fuse_load
            |=> term_trim_a_out == $past(reg_wdata);
    endproperty
    a_terma_wr: assert property (p_terma_wr)
        else $error("term trim a write not taken");

    // only the low nibble of a bandgap write is kept
    property p_bg_wr;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_BANDGAP_TRIM && !fuse_load
            |=> bandgap_trim_out == $past(reg_wdata[3:0]);
    endproperty
    a_bg_wr: assert property (p_bg_wr)
        else $error("bandgap trim write not taken");

    // software may switch dither off and back on
    property p_dith_en_wr;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_DITHER_CTRL && !fuse_load
            |=> dither_enable == $past(reg_wdata[0]);
    endproperty
    a_dith_en_wr: assert property (p_dith_en_wr)
        else $error("dither enable write not taken");

    property p_termb_wr;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_TERM_TRIM_B && !fuse_load
            |=> term_trim_b_out == $past(reg_wdata);
    endproperty
    a_termb_wr: assert property (p_termb_wr)
        else $error("term trim b write not taken");

    property p_amp_wr;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_DITHER_CTRL && !fuse_load
            |=> dither_amplitude_select == $past(reg_wdata[1])
            && rounding_error_select == $past(reg_wdata[2]);
    endproperty
    a_amp_wr: assert property (p_amp_wr)
        else $error("dither control write not taken");

    property p_dual;
        @(posedge sys_clk) disable iff (rst)
        !single_channel && $past(reg_wr && reg_addr == OFS_B0_TIME_ZERO
            && !fuse_load) |-> bank0_timing_out == $past(reg_wdata);
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual mode timing trim wrong");

    property p_single;
        @(posedge sys_clk) disable iff (rst)
        single_channel && $past(reg_wr && reg_addr == OFS_B0_TIME_QUAD
            && !fuse_load) |-> bank0_timing_out == $past(reg_wdata);
    endproperty
    a_single: assert property (p_single)
        else $error("single mode timing trim wrong");

    property p_fuse;
        @(posedge sys_clk) disable iff (rst)
        fuse_load |=> rst || (gain_trim_b_out == $past(fuse_gain_trim_b)
            && fuse_loaded);
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("fuse default not loaded");
endmodule

/* File: tb/atd_regs_tb.sv */
// bench for the trim and dither register bank: reset, fuse load, rows
// assumes one-cycle read latency and a single fuse copy per reset
`timescale 1ns/10ps
module atd_regs_tb;
    import atd_pkg::*;
    // ==================================================
    // stimulus and observed signals
    logic sys_clk = 1'b0; // 5 ns period
    logic rst = 1'b1; // held for 20 cycles at start
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic fuse_ready = 1'b0; // fuses invalid until raised
    logic single_channel = 1'b0; // dual mode first
    logic [7:0] fz [7] = '{8'hA5, 8'hF3, 8'h3C, 8'hC3, 8'hFE, 8'h11, 8'h22};
    logic [7:0] gt, ta, tb, b0;
    logic [3:0] bg;
    logic den, damp, derr, fl_o;
    logic [7:0] sh [7]; // expected register contents
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    // ==================================================
    // row table: address, write data, read-back, shadow slot
    localparam int NR = 12;
    localparam logic [11:0] RA [NR] = '{OFS_GAIN_TRIM_B, OFS_BANDGAP_TRIM,
        OFS_TERM_TRIM_A, OFS_TERM_TRIM_B, OFS_DITHER_CTRL, OFS_DITHER_CTRL,
        OFS_DITHER_CTRL, OFS_DITHER_CTRL, OFS_B0_TIME_ZERO, OFS_B0_TIME_QUAD,
        12'h07D, 12'h17B};
    localparam logic [7:0] WD [NR] = '{8'h5A, 8'hFF, 8'h81, 8'h7E, 8'hFF,
        8'hF8, 8'h02, 8'h05, 8'h96, 8'h69, 8'hFF, 8'hFF};
    localparam logic [7:0] RX [NR] = '{8'h5A, 8'h0F, 8'h81, 8'h7E, 8'h07,
        8'h00, 8'h02, 8'h05, 8'h96, 8'h69, 8'h00, 8'h00};
    localparam int RI [NR] = '{0, 1, 2, 3, 4, 4, 4, 4, 5, 6, -1, -1};

    atd_regs DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fuse_ready(fuse_ready),
        .fuse_gain_trim_b(fz[0]), .fuse_bandgap_trim(fz[1]),
        .fuse_term_trim_a(fz[2]), .fuse_term_trim_b(fz[3]),
        .fuse_dither_control(fz[4]), .fuse_b0_time_zero(fz[5]),
        .fuse_b0_time_quad(fz[6]), .single_channel(single_channel),
        .gain_trim_b_out(gt), .bandgap_trim_out(bg), .term_trim_a_out(ta),
        .term_trim_b_out(tb), .dither_enable(den),
        .dither_amplitude_select(damp), .rounding_error_select(derr),
        .bank0_timing_out(b0), .fuse_loaded(fl_o));

    // ==================================================
    // clock and hang guard (run needs well under 1000 cycles)
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end

    // ==================================================
    // helpers: compare, bus cycles, output sweep
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // settled outputs sampled on the falling edge, returns on a rising one
    task automatic chk_outs(input logic fl);
        @(negedge sys_clk);
        cmp(gt, sh[0], "gain");
        cmp({4'h0, bg}, sh[1], "bandgap");
        cmp(ta, sh[2], "term a");
        cmp(tb, sh[3], "term b");
        cmp({5'h00, derr, damp, den}, sh[4], "dither");
        cmp(b0, single_channel ? sh[6] : sh[5], "bank0");
        cmp({7'h00, fl_o}, {7'h00, fl}, "loaded");
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        cmp(reg_rdata, e, "read");
        @(posedge sys_clk);
    endtask
    task automatic rd_all();
        for (int i = 0; i < NR; i++) begin
            if (RI[i] >= 0) begin
                rd(RA[i], sh[RI[i]]);
            end
        end
    endtask
    // fuse copy lands on the third edge after fuse_ready, not before
    task automatic load_fuse();
        fuse_ready <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk_outs(1'b0);
        foreach (sh[k]) sh[k] = fz[k];
        sh[1] = fz[1] & BANDGAP_TRIM_MASK;
        sh[4] = fz[4] & DITH_MASK;
        chk_outs(1'b1);
        rd_all();
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==================================================
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        sh = '{8'h00, 8'h00, 8'h00, 8'h00, DITH_RESET, 8'h00, 8'h00};
        chk_outs(1'b0);
        rd_all();
        load_fuse();
        // ordinary rows, unmapped and aliased addresses last
        for (int i = 0; i < NR; i++) begin
            wr(RA[i], WD[i]);
            if (RI[i] >= 0) sh[RI[i]] = RX[i];
            chk_outs(1'b1);
            rd(RA[i], RX[i]);
        end
        // clocking mode picks which bank0 trim drives the output
        single_channel <= 1'b1;
        @(posedge sys_clk);
        chk_outs(1'b1);
        wr(OFS_B0_TIME_QUAD, 8'hE7);
        sh[6] = 8'hE7;
        chk_outs(1'b1);
        single_channel <= 1'b0;
        @(posedge sys_clk);
        chk_outs(1'b1);
        // write then two reads with no gap, then idle read data
        reg_addr <= OFS_GAIN_TRIM_B;
        reg_wdata <= 8'hC3;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_addr <= OFS_BANDGAP_TRIM;
        @(negedge sys_clk);
        cmp(reg_rdata, 8'hC3, "b2b gain");
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        cmp(reg_rdata, sh[1], "b2b bandgap");
        @(negedge sys_clk);
        cmp(reg_rdata, 8'h00, "idle rdata");
        @(posedge sys_clk);
        // second reset mid-run restores defaults, then fuses again
        fuse_ready <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        sh = '{8'h00, 8'h00, 8'h00, 8'h00, DITH_RESET, 8'h00, 8'h00};
        chk_outs(1'b0);
        rd(OFS_DITHER_CTRL, DITH_RESET);
        load_fuse();
        end_sim();
    end
endmodule
